// ==== core/sic_switch_ctrl.sv ====
`timescale 1ns/1ns
module sic_switch_ctrl
  import sic_pkg::*;
(
  input  wire logic               clk_in,
  input  wire logic               sys_rst_in,
  input  wire logic               cmd_valid_in,
  input  wire sic_pkg::sic_cmd_s  cmd_in,
  input  wire logic               status_read_in,
  input  wire logic               gate_in_one_in,
  input  wire logic               gate_in_two_in,
  input  wire logic               gate_in_three_in,
  input  wire logic [7:0]         comp_raw_in,
  input  wire logic [7:0]         overtemp_raw_in,
  input  wire logic               sleep_mode_in,
  input  wire logic               lowpower_req_in,
  output logic [7:0]              hs_on_out,
  output logic [2:0]              ls_on_out,
  output logic                    slope_ctrl_disable_out,
  output logic                    current_halve_out,
  output logic [7:0]              comp_enable_out,
  output sic_pkg::sic_div_s       divider_output_pin_out,
  output logic [15:0]             status_out,
  output logic                    lowpower_ok_out,
  output logic                    lowpower_active_out,
  output logic                    wake_out,
  output logic                    irq_request_n_out,
  output logic                    irq_request_n_oe_n_out
);
  import sic_pkg::*;

  logic [2:0]       gate_s1;
  logic [2:0]       gate_s;
  logic [2:0]       gate_q;
  logic [7:0]       ot_s1;
  logic [7:0]       ot_s2;
  logic             ot_s;
  logic             ot_q;
  logic [7:0]       source_enable;
  logic [7:0]       direct_on_ctrl;
  logic [7:0]       change_irq_enable;
  logic [2:0]       sink_source_select;
  logic             slope_ctrl_disable;
  logic             current_halve;
  logic             prev_div_en;
  sic_div_s         div_cfg;
  logic [7:0]       drive;
  logic [7:0]       chan_on;
  logic [7:0]       channel_compare_flag;
  logic [7:0]       change;
  logic             any_change;
  logic             ot_event;
  logic [1:0]       irq_source_field;
  logic             irq_pending;
  logic [2:0]       gate_rise;
  logic             all_off;
  sic_pwr_e         pwr_state;
  sic_pwr_e         next_pwr_state;
  logic [15:0]      next_status;

  // Pins are asynchronous to clk_in
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      gate_s1 <= 3'h0;
      gate_s  <= 3'h0;
      gate_q  <= 3'h0;
      ot_s1   <= 8'h00;
      ot_s2   <= 8'h00;
      ot_q    <= 1'b0;
    end else begin
      gate_s1 <= {gate_in_three_in, gate_in_two_in, gate_in_one_in};
      gate_s  <= gate_s1;
      gate_q  <= gate_s;
      // Each monitor is synchronised on its own before the bits are merged
      ot_s1   <= overtemp_raw_in;
      ot_s2   <= ot_s1;
      ot_q    <= ot_s;
    end
  end

  assign ot_s      = |ot_s2;
  assign gate_rise = gate_s & ~gate_q;
  assign ot_event  = ot_s & ~ot_q;

  // Per-channel settings: only the addressed channel, only when programming
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      source_enable      <= {NCH{RST_SETTING}};
      direct_on_ctrl     <= {NCH{RST_SETTING}};
      change_irq_enable  <= {NCH{RST_SETTING}};
      sink_source_select <= {NSINK{RST_SETTING}};
    end else if (cmd_valid_in && cmd_in.program_en) begin
      for (int i = 0; i < NCH; i++) begin
        if (cmd_in.chan_sel == 3'(i)) begin
          source_enable[i]     <= cmd_in.src_en;
          direct_on_ctrl[i]    <= cmd_in.direct_on;
          change_irq_enable[i] <= cmd_in.irq_en;
        end
      end
      // Own loop keeps the sink index inside its three bits
      for (int j = 0; j < NSINK; j++) begin
        if (cmd_in.chan_sel == 3'(j)) begin
          sink_source_select[j] <= cmd_in.sink_sel;
        end
      end
    end
  end

  // Global slope setting only from non-programming words
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      slope_ctrl_disable <= RST_SETTING;
    end else if (cmd_valid_in && !cmd_in.program_en) begin
      slope_ctrl_disable <= cmd_in.slope_dis;
    end
  end

  // Halve and divider fields travel in every command word
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      current_halve <= RST_SETTING;
      div_cfg       <= '0;
      prev_div_en   <= RST_SETTING;
    end else if (cmd_valid_in) begin
      current_halve       <= cmd_in.halve;
      div_cfg.enable      <= cmd_in.div_en;
      div_cfg.from_channel <= cmd_in.div_en & cmd_in.div_src;
      div_cfg.chan        <= cmd_in.chan_sel;
      prev_div_en         <= cmd_in.div_en;
    end
  end

  generate
    for (genvar g = 0; g < NCH; g++) begin : g_chan
      assign drive[g]   = direct_on_ctrl[g] | gate_s[sic_gate_of(g)];
      assign chan_on[g] = source_enable[g] & drive[g] & ~ot_s;

      sic_change_detect u_detect (
        .clk_in         (clk_in),
        .sys_rst_in     (sys_rst_in),
        .comp_raw_in    (comp_raw_in[g]),
        .comp_active_in (comp_enable_out[g]),
        .drive_in       (drive[g]),
        .irq_en_in      (change_irq_enable[g]),
        .flag_out       (channel_compare_flag[g]),
        .change_out     (change[g])
      );
    end
  endgenerate

  assign any_change = |change;
  assign all_off    = ~|chan_on;

  // Drive outputs; sink mode only exists on the first three channels
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      hs_on_out              <= 8'h00;
      ls_on_out              <= 3'h0;
      slope_ctrl_disable_out <= 1'b0;
      current_halve_out      <= 1'b0;
      comp_enable_out        <= 8'h00;
      divider_output_pin_out <= '0;
      lowpower_ok_out        <= 1'b0;
    end else begin
      hs_on_out[7:NSINK]     <= chan_on[7:NSINK];
      hs_on_out[NSINK-1:0]   <= chan_on[NSINK-1:0] & ~sink_source_select;
      ls_on_out              <= chan_on[NSINK-1:0] & sink_source_select;
      slope_ctrl_disable_out <= slope_ctrl_disable;
      current_halve_out      <= current_halve;
      comp_enable_out        <= sleep_mode_in ? 8'h00 : source_enable;
      divider_output_pin_out <= div_cfg;
      lowpower_ok_out        <= all_off;
    end
  end

  // Sticky source field and request; an event in the read cycle wins
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irq_source_field <= IRQ_SRC_NONE;
      irq_pending      <= 1'b0;
    end else begin
      if (any_change) begin
        irq_source_field <= IRQ_SRC_CHANGE;
      end else if (status_read_in) begin
        irq_source_field <= IRQ_SRC_NONE;
      end
      if (any_change || ot_event) begin
        irq_pending <= 1'b1;
      end else if (status_read_in) begin
        irq_pending <= 1'b0;
      end
    end
  end

  // Open drain: the pin is only ever pulled low
  assign irq_request_n_out      = 1'b0;
  assign irq_request_n_oe_n_out = ~irq_pending;

  always_comb begin
    next_status = 16'h0000;
    next_status[STAT_FLAG_LSB +: NCH] = channel_compare_flag;
    next_status[STAT_SRC_LSB +: 2]    = irq_source_field;
    if (prev_div_en) begin
      next_status[STAT_ECHO_LSB +: 3] = div_cfg.chan;
      next_status[STAT_VBAT_BIT]      = ~div_cfg.from_channel;
    end else begin
      next_status[STAT_OTCS_BIT]      = ot_s;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      status_out <= 16'h0000;
    end else begin
      status_out <= next_status;
    end
  end

  always_comb begin
    next_pwr_state = pwr_state;
    case (pwr_state)
      SIC_ACTIVE: begin
        if (lowpower_req_in && all_off) begin
          next_pwr_state = SIC_LOWPOWER;
        end
      end
      SIC_LOWPOWER: begin
        if (|gate_rise || !all_off) begin
          next_pwr_state = SIC_ACTIVE;
        end
      end
      default: next_pwr_state = SIC_ACTIVE;
    endcase
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pwr_state <= SIC_ACTIVE;
      wake_out  <= 1'b0;
    end else begin
      pwr_state <= next_pwr_state;
      wake_out  <= (pwr_state == SIC_LOWPOWER) && (next_pwr_state == SIC_ACTIVE);
    end
  end

  assign lowpower_active_out = (pwr_state == SIC_LOWPOWER);

  property p_overtemp_off;
    @(posedge clk_in) disable iff (sys_rst_in)
    ot_s |=> hs_on_out == 8'h00 && ls_on_out == 3'h0;
  endproperty
  a_overtemp_off: assert property (p_overtemp_off)
    else $error("channel on in overtemp");

  property p_keep_enable;
    @(posedge clk_in) disable iff (sys_rst_in)
    ot_s && !cmd_valid_in |=> $stable(source_enable);
  endproperty
  a_keep_enable: assert property (p_keep_enable)
    else $error("overtemp changed enables");

  property p_program_load;
    @(posedge clk_in) disable iff (sys_rst_in)
    cmd_valid_in && cmd_in.program_en
      |=> source_enable[$past(cmd_in.chan_sel)] == $past(cmd_in.src_en)
          && direct_on_ctrl[$past(cmd_in.chan_sel)] == $past(cmd_in.direct_on);
  endproperty
  a_program_load: assert property (p_program_load)
    else $error("channel not loaded");

  property p_slope_hold;
    @(posedge clk_in) disable iff (sys_rst_in)
    cmd_valid_in && cmd_in.program_en |=> $stable(slope_ctrl_disable);
  endproperty
  a_slope_hold: assert property (p_slope_hold)
    else $error("slope changed by program");

  property p_slope_out;
    @(posedge clk_in) disable iff (sys_rst_in)
    cmd_valid_in && !cmd_in.program_en
      |=> ##1 slope_ctrl_disable_out == $past(cmd_in.slope_dis, 2);
  endproperty
  a_slope_out: assert property (p_slope_out) else $error("slope output wrong");

  property p_halve_out;
    @(posedge clk_in) disable iff (sys_rst_in)
    cmd_valid_in |=> ##1 current_halve_out == $past(cmd_in.halve, 2);
  endproperty
  a_halve_out: assert property (p_halve_out) else $error("halve output wrong");

  property p_comp_enable;
    @(posedge clk_in) disable iff (sys_rst_in)
    sleep_mode_in |=> comp_enable_out == 8'h00;
  endproperty
  a_comp_enable: assert property (p_comp_enable)
    else $error("comparator on in sleep");

  property p_irq_raise;
    @(posedge clk_in) disable iff (sys_rst_in)
    any_change |=> !irq_request_n_oe_n_out && irq_source_field == IRQ_SRC_CHANGE;
  endproperty
  a_irq_raise: assert property (p_irq_raise) else $error("state change not raised");

  property p_irq_release;
    @(posedge clk_in) disable iff (sys_rst_in)
    status_read_in && !any_change && !ot_event |=> irq_request_n_oe_n_out;
  endproperty
  a_irq_release: assert property (p_irq_release)
    else $error("request not released");

  sequence s_div_cmd;
    cmd_valid_in && cmd_in.div_en;
  endsequence

  sequence s_quiet;
    !cmd_valid_in;
  endsequence

  property p_addr_echo;
    @(posedge clk_in) disable iff (sys_rst_in)
    s_div_cmd ##1 s_quiet |=> status_out[14:12] == $past(cmd_in.chan_sel, 2);
  endproperty
  a_addr_echo: assert property (p_addr_echo)
    else $error("divider address not echoed");

  property p_divider;
    @(posedge clk_in) disable iff (sys_rst_in)
    s_div_cmd ##1 s_quiet |=> divider_output_pin_out.enable
      && divider_output_pin_out.from_channel == $past(cmd_in.div_src, 2);
  endproperty
  a_divider: assert property (p_divider) else $error("divider setting wrong");

  property p_wake;
    @(posedge clk_in) disable iff (sys_rst_in)
    pwr_state == SIC_LOWPOWER && |gate_rise |=> pwr_state == SIC_ACTIVE ##0 wake_out;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on gate rise");

  // Sink channels count through the low side, so both drives are merged
  property p_direct_on;
    @(posedge clk_in) disable iff (sys_rst_in)
    !ot_s |=> ({hs_on_out[7:NSINK], hs_on_out[NSINK-1:0] | ls_on_out}
               & $past(source_enable & direct_on_ctrl))
              == $past(source_enable & direct_on_ctrl);
  endproperty
  a_direct_on: assert property (p_direct_on) else $error("direct-on channel off");

  property p_lp_entry;
    @(posedge clk_in) disable iff (sys_rst_in)
    pwr_state == SIC_ACTIVE && !all_off |=> pwr_state == SIC_ACTIVE;
  endproperty
  a_lp_entry: assert property (p_lp_entry) else $error("low-power while on");

  property p_src_clear;
    @(posedge clk_in) disable iff (sys_rst_in)
    status_read_in && !any_change |=> irq_source_field == IRQ_SRC_NONE;
  endproperty
  a_src_clear: assert property (p_src_clear) else $error("source not cleared");

endmodule : sic_switch_ctrl

// ==== core/sic_pkg.sv ====
package sic_pkg;

  localparam int NCH           = 8;
  localparam int NSINK         = 3;
  localparam int CLK_PERIOD_NS = 4;
  // Comparator debounce time; the analog figure is a plain default
  localparam int DEB_TIME_NS   = 100;
  localparam int DEB_CYCLES    = (DEB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEB_W         = 5;

  localparam logic RST_SETTING = 1'b0;

  localparam logic [1:0] IRQ_SRC_NONE   = 2'h0;
  localparam logic [1:0] IRQ_SRC_CHANGE = 2'h1;

  localparam int STAT_FLAG_LSB = 0;
  localparam int STAT_SRC_LSB  = 8;
  localparam int STAT_ECHO_LSB = 12;
  localparam int STAT_OTCS_BIT = 13;
  localparam int STAT_VBAT_BIT = 15;

  localparam logic [1:0] GATE_ONE   = 2'h0;
  localparam logic [1:0] GATE_TWO   = 2'h1;
  localparam logic [1:0] GATE_THREE = 2'h2;

  typedef struct packed {
    logic       program_en;
    logic [2:0] chan_sel;
    logic       src_en;
    logic       sink_sel;
    logic       irq_en;
    logic       direct_on;
    logic       slope_dis;
    logic       halve;
    logic       div_en;
    logic       div_src;
  } sic_cmd_s;

  typedef struct packed {
    logic       enable;
    logic       from_channel;
    logic [2:0] chan;
  } sic_div_s;

  typedef enum logic {SIC_ACTIVE, SIC_LOWPOWER} sic_pwr_e;

  // Gate pin that drives a given zero-based channel
  function automatic logic [1:0] sic_gate_of(input int ch);
    case (ch)
      0, 6, 7: sic_gate_of = GATE_ONE;
      1, 4, 5: sic_gate_of = GATE_TWO;
      default: sic_gate_of = GATE_THREE;
    endcase
  endfunction : sic_gate_of

endpackage : sic_pkg

// ==== core/sic_change_detect.sv ====
`timescale 1ns/1ns
module sic_change_detect
  import sic_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  input  wire logic comp_raw_in,
  input  wire logic comp_active_in,
  input  wire logic drive_in,
  input  wire logic irq_en_in,
  output logic      flag_out,
  output logic      change_out
);
  import sic_pkg::*;

  logic             sync1;
  logic             sync2;
  logic [DEB_W-1:0] deb_cnt;
  logic             drive_q;
  logic             latched;
  logic             fall;

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
    end else begin
      sync1 <= comp_raw_in;
      sync2 <= sync1;
    end
  end

  // A new level must hold for the whole debounce time
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      deb_cnt  <= '0;
      flag_out <= 1'b0;
    end else if (!comp_active_in) begin
      deb_cnt  <= '0;
      flag_out <= 1'b0;
    end else if (sync2 == flag_out) begin
      deb_cnt <= '0;
    end else if (deb_cnt == DEB_W'(DEB_CYCLES - 1)) begin
      deb_cnt  <= '0;
      flag_out <= sync2;
    end else begin
      deb_cnt <= deb_cnt + 1'b1;
    end
  end

  assign fall = drive_q & ~drive_in;

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      drive_q    <= 1'b0;
      latched    <= 1'b0;
      change_out <= 1'b0;
    end else begin
      drive_q    <= drive_in;
      change_out <= fall & (flag_out != latched) & irq_en_in;
      if (fall) begin
        latched <= flag_out;
      end
    end
  end

  property p_latch_on_fall;
    @(posedge clk_in) disable iff (sys_rst_in)
    drive_q && !drive_in |=> latched == $past(flag_out);
  endproperty
  a_latch_on_fall: assert property (p_latch_on_fall)
    else $error("latch missed fall");

  property p_change_irq;
    @(posedge clk_in) disable iff (sys_rst_in)
    fall && (flag_out != latched) && irq_en_in |=> change_out;
  endproperty
  a_change_irq: assert property (p_change_irq) else $error("change not reported");

  property p_flag_settle;
    @(posedge clk_in) disable iff (sys_rst_in)
    comp_active_in && $past(comp_active_in) && $changed(flag_out) |-> flag_out == $past(sync2);
  endproperty
  a_flag_settle: assert property (p_flag_settle)
    else $error("flag took unstable level");

endmodule : sic_change_detect

// ==== tb/sic_host_model.sv ====
`timescale 1ns/1ns
module sic_host_model (
  input  wire logic              clk_in,
  input  wire logic              send_in,
  input  wire sic_pkg::sic_cmd_s word_in,
  input  wire logic [2:0]        gates_in,
  input  wire logic              read_in,
  output sic_pkg::sic_cmd_s      cmd_out,
  output logic                   cmd_valid_out,
  output logic [2:0]             gates_out,
  output logic                   status_read_out
);
  import sic_pkg::*;

  initial begin
    cmd_out         = '0;
    cmd_valid_out   = 1'b0;
    gates_out       = 3'h0;
    status_read_out = 1'b0;
  end

  // Words leave only as whole decoded commands; one valid cycle per request
  always @(posedge clk_in) begin
    cmd_valid_out <= send_in;
    if (send_in) begin
      cmd_out <= word_in;
    end
    gates_out       <= gates_in;
    status_read_out <= read_in;
  end
endmodule : sic_host_model

// ==== tb/switch_interface_control_test.sv ====
`timescale 1ns/1ns
module switch_interface_control_test;
  import sic_pkg::*;

  logic       clk_in, sys_rst_in, send, read_req, sleep_mode, lp_req;
  logic [2:0] gates, gate_pin, ls_on;
  logic [7:0] comp_raw, ot_raw, hs_on, comp_en, exp_mask [3];
  logic       cmd_valid, status_read, slope, halve, lp_ok, lp_act, wake, irq_n, oe_n;
  logic [15:0] status;
  sic_cmd_s   word, cmd;
  sic_div_s   div;
  int         n_fail, checks;

  sic_host_model host (.clk_in(clk_in), .send_in(send), .word_in(word), .gates_in(gates),
    .read_in(read_req), .cmd_out(cmd), .cmd_valid_out(cmd_valid), .gates_out(gate_pin),
    .status_read_out(status_read));

  sic_switch_ctrl dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .cmd_valid_in(cmd_valid),
    .cmd_in(cmd), .status_read_in(status_read), .gate_in_one_in(gate_pin[0]),
    .gate_in_two_in(gate_pin[1]), .gate_in_three_in(gate_pin[2]), .comp_raw_in(comp_raw),
    .overtemp_raw_in(ot_raw), .sleep_mode_in(sleep_mode), .lowpower_req_in(lp_req),
    .hs_on_out(hs_on), .ls_on_out(ls_on), .slope_ctrl_disable_out(slope),
    .current_halve_out(halve), .comp_enable_out(comp_en), .divider_output_pin_out(div),
    .status_out(status), .lowpower_ok_out(lp_ok), .lowpower_active_out(lp_act),
    .wake_out(wake), .irq_request_n_out(irq_n), .irq_request_n_oe_n_out(oe_n));

  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask : cyc

  function automatic sic_cmd_s mk(input logic p, input logic [2:0] sel, input logic [7:0] f);
    mk = '{p, sel, f[7], f[6], f[5], f[4], f[3], f[2], f[1], f[0]};
  endfunction : mk

  // Host path adds one cycle ahead of the two the core needs
  task automatic send_cmd(input sic_cmd_s c);
    word <= c;
    send <= 1'b1;
    cyc(1);
    send <= 1'b0;
    cyc(4);
  endtask : send_cmd

  task automatic do_reset;
    sys_rst_in <= 1'b1;
    cyc(6);
    sys_rst_in <= 1'b0;
    cyc(1);
  endtask : do_reset

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  task automatic t_reset;
    do_reset();
    check("hs_on", hs_on, 16'h0000);
    check("ls_on", ls_on, 16'h0000);
    check("status", status, 16'h0000);
    check("oe_n", oe_n, 16'h0001);
    check("slope", {slope, halve}, 16'h0000);
    check("irq_n", irq_n, 16'h0000);
  endtask : t_reset

  task automatic t_direct;
    do_reset();
    send_cmd(mk(1'b1, 3'h0, 8'h90));
    check("hs_on", hs_on, 16'h0001);
    send_cmd(mk(1'b1, 3'h0, 8'hD0));
    check("hs_on", hs_on, 16'h0000);
    check("ls_on", ls_on, 16'h0001);
    send_cmd(mk(1'b1, 3'h3, 8'hD0));
    check("hs_on", hs_on, 16'h0008);
    // Global word carries channel bits that must be ignored
    send_cmd(mk(1'b0, 3'h3, 8'h0C));
    check("hs_on", hs_on, 16'h0008);
    check("slope", slope, 16'h0001);
    check("halve", halve, 16'h0001);
    send_cmd(mk(1'b1, 3'h3, 8'h00));
    check("slope", slope, 16'h0001);
    check("hs_on", hs_on, 16'h0000);
    check("halve", halve, 16'h0000);
    check("ls_on", ls_on, 16'h0001);
  endtask : t_direct

  task automatic t_gates;
    do_reset();
    for (int ch = 0; ch < NCH; ch++) begin
      send_cmd(mk(1'b1, ch[2:0], 8'h80));
    end
    check("hs_on", hs_on, 16'h0000);
    check("lp_ok", lp_ok, 16'h0001);
    lp_req <= 1'b1;
    cyc(3);
    check("lp_act", lp_act, 16'h0001);
    gates <= 3'b001;
    for (int i = 0; i < 12 && wake !== 1'b1; i++) begin
      cyc(1);
    end
    check("wake", wake, 16'h0001);
    check("lp_act", lp_act, 16'h0000);
    lp_req <= 1'b0;
    cyc(3);
    check("hs_on", hs_on, exp_mask[0]);
    for (int g = 1; g < 3; g++) begin
      gates <= 3'b001 << g;
      cyc(6);
      check("hs_on", hs_on, exp_mask[g]);
    end
    gates <= 3'b000;
    cyc(6);
  endtask : t_gates

  task automatic t_divider;
    do_reset();
    send_cmd(mk(1'b0, 3'h5, 8'h00));
    check("div_en", div.enable, 16'h0000);
    send_cmd(mk(1'b0, 3'h5, 8'h02));
    check("div", {div.enable, div.from_channel}, 16'h0002);
    check("vbat", status[STAT_VBAT_BIT], 16'h0001);
    send_cmd(mk(1'b0, 3'h5, 8'h03));
    check("div", div, 16'h001D);
    check("echo", status[14:12], 16'h0005);
    check("vbat", status[STAT_VBAT_BIT], 16'h0000);
  endtask : t_divider

  task automatic t_change;
    do_reset();
    send_cmd(mk(1'b1, 3'h0, 8'hA0));
    check("comp_en", comp_en, 16'h0001);
    comp_raw <= 8'h01;
    gates    <= 3'b001;
    cyc(40);
    check("flags", status[7:0], 16'h0001);
    check("oe_n", oe_n, 16'h0001);
    gates <= 3'b000;
    cyc(8);
    check("oe_n", oe_n, 16'h0000);
    check("src", status[9:8], IRQ_SRC_CHANGE);
    read_req <= 1'b1;
    cyc(1);
    read_req <= 1'b0;
    cyc(3);
    check("oe_n", oe_n, 16'h0001);
    check("src", status[9:8], IRQ_SRC_NONE);
    // Same comparator level latched again is not a change
    gates <= 3'b001;
    cyc(6);
    gates <= 3'b000;
    cyc(8);
    check("oe_n", oe_n, 16'h0001);
    sleep_mode <= 1'b1;
    cyc(3);
    check("comp_en", comp_en, 16'h0000);
    sleep_mode <= 1'b0;
    comp_raw   <= 8'h00;
  endtask : t_change

  task automatic t_overtemp;
    do_reset();
    send_cmd(mk(1'b1, 3'h0, 8'h90));
    ot_raw <= 8'h04;
    cyc(5);
    check("hs_on", hs_on, 16'h0000);
    check("oe_n", oe_n, 16'h0000);
    check("otcs", status[STAT_OTCS_BIT], 16'h0001);
    ot_raw <= 8'h00;
    cyc(5);
    check("hs_on", hs_on, 16'h0001);
    check("otcs", status[STAT_OTCS_BIT], 16'h0000);
  endtask : t_overtemp

  initial begin
    #40000;
    n_fail++;
    stop_test();
  end

  initial begin
    sys_rst_in = 1'b1;
    {send, read_req, sleep_mode, lp_req} = 4'h0;
    {gates, comp_raw, ot_raw} = '0;
    word = '0;
    exp_mask = '{8'hC1, 8'h32, 8'h0C};
    n_fail = 0;
    checks = 0;
    t_reset();
    t_direct();
    t_gates();
    t_divider();
    t_change();
    t_overtemp();
    stop_test();
  end
endmodule : switch_interface_control_test
